// >>> verilog/sbst_pkg.sv
// package: constants, types and encodings of the sram boundary-scan test port
package sbst_pkg;

   // instruction register layout
   localparam int          SBST_IR_W       = 3;
   localparam logic [1:0]  SBST_IR_CAPT    = 2'h1;

   // instruction encodings; the three codes not listed are reserved
   localparam logic [2:0]  SBST_INS_EXTEST = 3'h0;
   localparam logic [2:0]  SBST_INS_IDCODE = 3'h1;
   localparam logic [2:0]  SBST_INS_SAMPZ  = 3'h2;
   localparam logic [2:0]  SBST_INS_SAMPLE = 3'h4;
   localparam logic [2:0]  SBST_INS_BYPASS = 3'h7;

   // data register sizes and reset values
   localparam int          SBST_ID_W       = 32;
   localparam int          SBST_BSR_LEN    = 96;
   localparam int          SBST_HIZ_BIT    = 89;
   localparam logic        SBST_BYP_CAPT   = 1'h0;
   localparam logic        SBST_HIZ_RST    = 1'h1;

   // identification value; arbitrary, bit 0 set as the id format needs
   localparam logic [31:0] SBST_IDCODE_VAL = 32'h0A5C_3001;

   // controller states
   typedef enum logic [3:0] {
      ST_TLR,
      ST_RTI,
      ST_SEL_DR,
      ST_CAP_DR,
      ST_SH_DR,
      ST_EX1_DR,
      ST_PA_DR,
      ST_EX2_DR,
      ST_UPD_DR,
      ST_SEL_IR,
      ST_CAP_IR,
      ST_SH_IR,
      ST_EX1_IR,
      ST_PA_IR,
      ST_EX2_IR,
      ST_UPD_IR
   } sbst_state_e;

   // output-ring control handed to the memory clock domain
   typedef struct packed {
      logic drive_ext;
      logic bus_hiz;
   } sbst_mode_s;

   localparam sbst_mode_s  SBST_MODE_RST   = '{drive_ext: 1'b0, bus_hiz: 1'b0};

endpackage

// >>> verilog/sbst_sync2.sv
// module: two-flop level synchroniser of parameterised width
`timescale 1ns/1ps
module sbst_sync2 #(
   parameter int W = 1
) (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] d,
   output logic      [W-1:0] q
);
   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         meta_r <= '0;
         q      <= '0;
      end else begin
         meta_r <= d;
         q      <= meta_r;
      end
   end
endmodule

// >>> verilog/sbst_rst_sync.sv
// module: reset for the test-clock domain, asserts at once, releases on clock
`timescale 1ns/1ps
module sbst_rst_sync (
   input  wire logic clk,
   input  wire logic arst_n,
   output logic      rst_n_out
);
   logic meta_r;

   // asserts without a clock so a stopped test clock still sees reset
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         meta_r    <= 1'b0;
         rst_n_out <= 1'b0;
      end else begin
         meta_r    <= 1'b1;
         rst_n_out <= meta_r;
      end
   end
endmodule

// >>> verilog/sbst_tap.sv
// module: boundary-scan test access port of a synchronous burst sram
//
// Overview of operation
// - standard test port with five test registers
// - controller, instruction, boundary, bypass, id registers
// - test clock drives only test-port logic
// - all test inputs captured on rising edge
// - serial output changes on falling edge only
// - sixteen-state controller steered by mode select
// - unconnected mode select and data read high
// - instruction picks register between serial ports
// - selected register shifts one bit per clock
// - shifted-out bits appear on serial output
// - serial input enters most significant bit
// - serial output taken from least significant bit
// - output driver enabled only where states need
// - five high mode edges force reset state
// - test reset leaves memory operation untouched
// - power-up resets controller, output high impedance
// - three-bit instruction, id instruction after reset
// - instruction capture loads low bits 01
// - bypass bit captures zero under bypass
// - id instruction captures fixed 32-bit code
`timescale 1ns/1ps
module sbst_tap
   import sbst_pkg::*;
#(
   parameter int          BSR_LEN = sbst_pkg::SBST_BSR_LEN,
   parameter int          HIZ_BIT = sbst_pkg::SBST_HIZ_BIT,
   parameter logic [31:0] ID_VAL  = sbst_pkg::SBST_IDCODE_VAL
) (
   input  wire logic                 mclk,
   input  wire logic                 rst_n,
   input  wire logic                 tck,
   input  wire logic                 tms_i,
   input  wire logic                 tms_drv,
   input  wire logic                 tdi_i,
   input  wire logic                 tdi_drv,
   output logic                      tdo_o,
   output logic                      tdo_oe,
   input  wire logic [BSR_LEN-1:0]   ring_in,
   output logic      [BSR_LEN-1:0]   ring_out,
   output sbst_pkg::sbst_mode_s      ring_mode
);
   import sbst_pkg::*;

   // ---------------- test-clock domain ----------------
   // the five test units below (controller, instruction, bypass, id and
   // boundary stages) form the test registers; synchronisers, mode register and output stage sit beside them

   logic                  tck_rst_n;
   logic                  tms;
   logic                  tdi;
   sbst_state_e           st_r;
   sbst_state_e           st_nxt;
   logic [SBST_IR_W-1:0]  ir_sh_r;
   logic [SBST_IR_W-1:0]  ir_r;
   logic                  byp_r;
   logic [SBST_ID_W-1:0]  id_sh_r;
   logic [BSR_LEN-1:0]    bsr_sh_r;
   logic [BSR_LEN-1:0]    bsr_upd_r;
   logic [BSR_LEN-1:0]    ring_tck;
   logic                  upd_tgl_r;
   sbst_mode_s            mode_r;
   logic                  tdo_r;
   logic                  tdo_oe_r;

   // a pin left open reads high, as its pull-up would make it
   assign tms = tms_drv ? tms_i : 1'b1;
   assign tdi = tdi_drv ? tdi_i : 1'b1;

   // power-up reset reaches the port even while the test clock is held low
   sbst_rst_sync u_rst (
      .clk       (tck),
      .arst_n    (rst_n),
      .rst_n_out (tck_rst_n)
   );

   // controller state register, advanced on the rising test clock edge
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         st_r <= ST_TLR;
      end else begin
         st_r <= st_nxt;
      end
   end

   // next state from mode select; five highs reach reset from anywhere
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         ST_TLR: begin
            st_nxt = tms ? ST_TLR : ST_RTI;
         end
         ST_RTI: begin
            st_nxt = tms ? ST_SEL_DR : ST_RTI;
         end
         ST_SEL_DR: begin
            st_nxt = tms ? ST_SEL_IR : ST_CAP_DR;
         end
         ST_CAP_DR: begin
            st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         end
         ST_SH_DR: begin
            st_nxt = tms ? ST_EX1_DR : ST_SH_DR;
         end
         ST_EX1_DR: begin
            st_nxt = tms ? ST_UPD_DR : ST_PA_DR;
         end
         ST_PA_DR: begin
            st_nxt = tms ? ST_EX2_DR : ST_PA_DR;
         end
         ST_EX2_DR: begin
            st_nxt = tms ? ST_UPD_DR : ST_SH_DR;
         end
         ST_UPD_DR: begin
            st_nxt = tms ? ST_SEL_DR : ST_RTI;
         end
         ST_SEL_IR: begin
            st_nxt = tms ? ST_TLR : ST_CAP_IR;
         end
         ST_CAP_IR: begin
            st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         end
         ST_SH_IR: begin
            st_nxt = tms ? ST_EX1_IR : ST_SH_IR;
         end
         ST_EX1_IR: begin
            st_nxt = tms ? ST_UPD_IR : ST_PA_IR;
         end
         ST_PA_IR: begin
            st_nxt = tms ? ST_EX2_IR : ST_PA_IR;
         end
         ST_EX2_IR: begin
            st_nxt = tms ? ST_UPD_IR : ST_SH_IR;
         end
         ST_UPD_IR: begin
            st_nxt = tms ? ST_SEL_DR : ST_RTI;
         end
      endcase
   end

   // state decode; the pause and exit states only hold registers,
   // so they need no decode of their own
   wire in_tlr    = (st_r == ST_TLR);
   wire in_cap_dr = (st_r == ST_CAP_DR);
   wire in_sh_dr  = (st_r == ST_SH_DR);
   wire in_upd_dr = (st_r == ST_UPD_DR);
   wire in_cap_ir = (st_r == ST_CAP_IR);
   wire in_sh_ir  = (st_r == ST_SH_IR);
   wire in_upd_ir = (st_r == ST_UPD_IR);

   // instruction decode; reserved codes fall back to the bypass path
   wire ins_extest = (ir_r == SBST_INS_EXTEST);
   wire ins_sampz  = (ir_r == SBST_INS_SAMPZ);
   wire ins_sample = (ir_r == SBST_INS_SAMPLE);
   wire sel_id     = (ir_r == SBST_INS_IDCODE);
   wire sel_bsr    = ins_extest | ins_sampz | ins_sample;
   wire sel_byp    = ~sel_id & ~sel_bsr;

   // instruction shift stage: capture pattern, shift toward the low end
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_sh_r <= SBST_INS_IDCODE;
      end else if (in_cap_ir) begin
         ir_sh_r <= {ir_r[SBST_IR_W-1], SBST_IR_CAPT};
      end else if (in_sh_ir) begin
         ir_sh_r <= {tdi, ir_sh_r[SBST_IR_W-1:1]};
      end
   end

   // current instruction; falls back to the id read on every reset
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         ir_r <= SBST_INS_IDCODE;
      end else if (in_tlr) begin
         ir_r <= SBST_INS_IDCODE;
      end else if (in_upd_ir) begin
         ir_r <= ir_sh_r;
      end
   end

   // single-bit bypass path; reserved codes land here too, so a stray
   // code shifts through one bit and drives nothing
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         byp_r <= SBST_BYP_CAPT;
      end else if (sel_byp && in_cap_dr) begin
         byp_r <= SBST_BYP_CAPT;
      end else if (sel_byp && in_sh_dr) begin
         byp_r <= tdi;
      end
   end

   // identification register, loaded with the fixed code on capture;
   // the reload means a second read never shows bits shifted in before
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         id_sh_r <= ID_VAL;
      end else if (sel_id && in_cap_dr) begin
         id_sh_r <= ID_VAL;
      end else if (sel_id && in_sh_dr) begin
         id_sh_r <= {tdi, id_sh_r[SBST_ID_W-1:1]};
      end
   end

   // ring pins are asynchronous to the test clock; two flops first.
   // a ring bit moving near the capture edge may still come in either way
   sbst_sync2 #(
      .W (BSR_LEN)
   ) u_ring_sync (
      .clk   (tck),
      .rst_n (tck_rst_n),
      .d     (ring_in),
      .q     (ring_tck)
   );

   // boundary shift stage: snapshot on capture, serial shift after
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_sh_r <= '0;
      end else if (sel_bsr && in_cap_dr) begin
         bsr_sh_r <= ring_tck;
      end else if (sel_bsr && in_sh_dr) begin
         bsr_sh_r <= {tdi, bsr_sh_r[BSR_LEN-1:1]};
      end
   end

   // preload latch holds the drive pattern; bus-enable cell presets high
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         bsr_upd_r          <= '0;
         bsr_upd_r[HIZ_BIT] <= SBST_HIZ_RST;
      end else if (in_tlr) begin
         bsr_upd_r          <= '0;
         bsr_upd_r[HIZ_BIT] <= SBST_HIZ_RST;
      end else if (sel_bsr && in_upd_dr) begin
         bsr_upd_r          <= bsr_sh_r;
      end
   end

   // toggle tells the memory domain that the preload latch has moved;
   // the latch then stays still for at least three test clocks
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         upd_tgl_r <= 1'b0;
      end else if ((sel_bsr && in_upd_dr) || in_tlr) begin
         upd_tgl_r <= ~upd_tgl_r;
      end
   end

   // ring control; only the output-ring instructions reach the memory
   wire        hiz_cell = bsr_upd_r[HIZ_BIT];
   sbst_mode_s mode_nxt;
   assign mode_nxt.drive_ext = ins_extest;
   assign mode_nxt.bus_hiz   = ins_sampz | (ins_extest & ~hiz_cell);

   // registered so the crossing sees no decode glitches; limitation: with
   // the test clock stopped, a new instruction reaches the ring mode only
   // after one more test clock
   always_ff @(posedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         mode_r <= SBST_MODE_RST;
      end else begin
         mode_r <= mode_nxt;
      end
   end

   // serial output source: the low end of whichever register is shifting
   wire dr_lsb = sel_id  ? id_sh_r[0]  :
                 sel_bsr ? bsr_sh_r[0] : byp_r;
   wire tdo_nxt   = in_sh_ir ? ir_sh_r[0] : dr_lsb;
   wire tdo_oe_nx = in_sh_ir | in_sh_dr;

   // output stage on the falling edge, half a clock after the state moves;
   // this gives the next device's rising-edge sample half a clock of margin
   always_ff @(negedge tck or negedge tck_rst_n) begin
      if (!tck_rst_n) begin
         tdo_r    <= 1'b0;
         tdo_oe_r <= 1'b0;
      end else begin
         tdo_r    <= tdo_nxt;
         tdo_oe_r <= tdo_oe_nx;
      end
   end

   assign tdo_o  = tdo_r;
   assign tdo_oe = tdo_oe_r;

   // ---------------- memory-clock domain ----------------
   // test state enters here through synchronisers, or for the preload word behind a synchronised toggle, so a port reset or
   // idle test clock never disturbs memory timing

   sbst_mode_s  mode_mclk;
   logic        tgl_mclk;
   logic        tgl_seen_r;
   logic [BSR_LEN-1:0] ring_out_r;
   sbst_mode_s  ring_mode_r;

   // mode bits are levels, two flops each
   sbst_sync2 #(
      .W ($bits(sbst_mode_s))
   ) u_mode_sync (
      .clk   (mclk),
      .rst_n (rst_n),
      .d     (mode_r),
      .q     (mode_mclk)
   );

   // update toggle carried as a level, edge found after the second flop
   sbst_sync2 #(
      .W (1)
   ) u_tgl_sync (
      .clk   (mclk),
      .rst_n (rst_n),
      .d     (upd_tgl_r),
      .q     (tgl_mclk)
   );

   wire tgl_edge = tgl_mclk ^ tgl_seen_r;

   // copy the preload word once its toggle has crossed; the word is
   // stable long before, which is what makes this copy safe
   always_ff @(posedge mclk) begin
      if (!rst_n) begin
         tgl_seen_r <= 1'b0;
         ring_out_r <= '0;
         ring_mode_r <= SBST_MODE_RST;
      end else begin
         tgl_seen_r  <= tgl_mclk;
         ring_mode_r <= mode_mclk;
         if (tgl_edge) begin
            ring_out_r <= bsr_upd_r;
         end
      end
   end

   assign ring_out  = ring_out_r;
   assign ring_mode = ring_mode_r;

endmodule

// >>> testbench/sbst_tap_assertions.sv
// checker: timing relations on the test port pins
`timescale 1ns/1ps
module sbst_tap_assertions
   import sbst_pkg::*;
#(
   parameter int          BSR_LEN = sbst_pkg::SBST_BSR_LEN,
   parameter logic [31:0] ID_VAL  = sbst_pkg::SBST_IDCODE_VAL
) (
   input wire logic               mclk,
   input wire logic               rst_n,
   input wire logic               tck,
   input wire logic               tms_i,
   input wire logic               tms_drv,
   input wire logic               tdi_i,
   input wire logic               tdi_drv,
   input wire logic               tdo_o,
   input wire logic               tdo_oe,
   input wire logic [BSR_LEN-1:0] ring_in,
   input wire logic [BSR_LEN-1:0] ring_out,
   input wire sbst_pkg::sbst_mode_s ring_mode
);
   import sbst_pkg::*;
   logic       tms_eff;
   logic [1:0] tdo_rise_r;
   bit         tck_seen_r;
   // an open mode pin reads high
   assign tms_eff = tms_drv ? tms_i : 1'b1;
   // output pair as it stood at the last rising edge; the falling edge must find it unmoved.
   // the flag keeps the parked clock's first settle at power-up out of the check
   always_ff @(posedge tck) begin
      tck_seen_r <= 1'b1;
      tdo_rise_r <= {tdo_oe, tdo_o};
   end
   sequence s_tap_reset;
      tms_eff [*5];
   endsequence
   sequence s_to_shift_dr;
      !tms_eff ##1 tms_eff ##1 !tms_eff [*2];
   endsequence
   sequence s_to_shift_ir;
      !tms_eff ##1 tms_eff [*2] ##1 !tms_eff [*2];
   endsequence
   chk_tdo_falling_only: assert property (@(negedge tck) disable iff (!rst_n)
      tck_seen_r |-> {tdo_oe, tdo_o} == tdo_rise_r) else $error("tdo moved away from the falling edge");
   chk_five_high_reset: assert property (@(posedge tck) disable iff (!rst_n)
      s_tap_reset ##1 !tms_eff |=> !tdo_oe [*2]) else $error("tdo driven after mode reset");
   chk_oe_enter_low: assert property (@(posedge tck) disable iff (!rst_n)
      $rose(tdo_oe) |-> !$past(tms_eff)) else $error("tdo enabled without shift entry");
   chk_oe_leave_high: assert property (@(posedge tck) disable iff (!rst_n)
      $fell(tdo_oe) |-> $past(tms_eff)) else $error("tdo released inside shift");
   chk_oe_stays_shift: assert property (@(posedge tck) disable iff (!rst_n)
      tdo_oe && !tms_eff |=> tdo_oe) else $error("tdo released while shifting");
   chk_id_first_bit: assert property (@(posedge tck) disable iff (!rst_n)
      s_tap_reset ##1 s_to_shift_dr |=> tdo_oe && tdo_o == ID_VAL[0]) else $error("id bit 0 wrong");
   chk_ir_capture_bits: assert property (@(posedge tck) disable iff (!rst_n)
      s_tap_reset ##1 s_to_shift_ir ##1 !tms_eff |=> tdo_oe && !tdo_o) else $error("ir capture bit 1 wrong");
   chk_ring_in_reset: assert property (@(posedge mclk)
      !rst_n |=> ring_out == '0 && ring_mode == SBST_MODE_RST) else $error("ring not cleared by reset");
endmodule
bind sbst_tap sbst_tap_assertions #(.BSR_LEN(BSR_LEN), .ID_VAL(ID_VAL)) sbst_tap_assertions_i (
   .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms_i(tms_i), .tms_drv(tms_drv), .tdi_i(tdi_i),
   .tdi_drv(tdi_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
   .ring_mode(ring_mode));

// >>> testbench/sbst_tester.sv
// partner: boundary-scan controller on the test pins
`timescale 1ns/1ps
module sbst_tester (
   output logic      tck,
   output logic      tms_i,
   output logic      tms_drv,
   output logic      tdi_i,
   output logic      tdi_drv,
   input  wire logic tdo_o,
   input  wire logic tdo_oe
);
   // clock parked low between frames so the port never ticks unasked
   initial begin
      tck = 1'b0;
      tms_i = 1'b1;
      tms_drv = 1'b1;
      tdi_i = 1'b0;
      tdi_drv = 1'b1;
   end
   // one 12 ns period; pins move while tck is low, an undriven tdo reads as the inverse of the bit sent
   task automatic step(input logic m, input logic d, output logic q);
      tms_i = m;
      tdi_i = d;
      #6 tck = 1'b1;
      q = tdo_oe ? tdo_o : ~d;
      #6 tck = 1'b0;
   endtask
   // six high edges, one spare for the reset release; open pin held low to prove the pull-up
   task automatic reset_tap(input bit open);
      logic q;
      tms_drv = !open;
      repeat (6) step(!open, ~tdi_i, q);
      tms_drv = 1'b1;
      step(1'b0, ~tdi_i, q);
   endtask
   // from idle: select, capture, shift n bits lsb first, update, back to idle
   task automatic scan(input bit ir, input bit open, input int n, input logic [31:0] din,
                       output logic [31:0] dout);
      logic q;
      dout = 32'h0000_0000;
      step(1'b1, ~tdi_i, q);
      if (ir) step(1'b1, ~tdi_i, q);
      step(1'b0, ~tdi_i, q);
      step(1'b0, ~tdi_i, q);
      tdi_drv = !open;
      for (int i = 0; i < n; i++) begin
         step(i == n - 1, din[i], q);
         dout[i] = q;
      end
      tdi_drv = 1'b1;
      step(1'b1, ~tdi_i, q);
      step(1'b0, ~tdi_i, q);
      // one idle clock in run-test lets the ring mode flop take a new instruction
      step(1'b0, ~tdi_i, q);
   endtask
endmodule

// >>> testbench/sbst_tap_test.sv
// testbench: every instruction scanned through the test port
`timescale 1ns/1ps
module sbst_tap_test;
   import sbst_pkg::*;
   typedef struct packed {
      logic [2:0]  ins;
      logic        open;
      logic [5:0]  len;
      logic [31:0] din;
      logic [31:0] dout;
   } sbst_row_s;
   logic        mclk;
   logic        rst_n;
   logic        tck;
   logic        tms_i;
   logic        tms_drv;
   logic        tdi_i;
   logic        tdi_drv;
   logic        tdo_o;
   logic        tdo_oe;
   logic [15:0] ring_in;
   logic [15:0] ring_out;
   sbst_mode_s  ring_mode;
   logic [31:0] got;
   int          mismatches;
   int          num_checks;
   // reserved codes must act as bypass; the open-tdi row shifts ones
   sbst_row_s   rows [9] = '{
      '{SBST_INS_IDCODE, 1'b0, 6'h20, 32'h0000_0000, SBST_IDCODE_VAL},
      '{SBST_INS_BYPASS, 1'b0, 6'h08, 32'h0000_00A5, 32'h0000_004A},
      '{3'h3, 1'b0, 6'h08, 32'h0000_00A5, 32'h0000_004A},
      '{3'h5, 1'b0, 6'h08, 32'h0000_00A5, 32'h0000_004A},
      '{3'h6, 1'b0, 6'h08, 32'h0000_00A5, 32'h0000_004A},
      '{SBST_INS_BYPASS, 1'b1, 6'h08, 32'h0000_0000, 32'h0000_00FE},
      '{SBST_INS_SAMPZ, 1'b0, 6'h10, 32'h0000_1234, 32'h0000_BEEF},
      '{SBST_INS_EXTEST, 1'b0, 6'h10, 32'h0000_5A5A, 32'h0000_BEEF},
      '{SBST_INS_SAMPLE, 1'b0, 6'h10, 32'h0000_3C96, 32'h0000_BEEF}};
   // short ring keeps scans brief; hiz cell moved to bit 9
   sbst_tap #(.BSR_LEN(16), .HIZ_BIT(9)) sbst_tap_i (
      .mclk(mclk), .rst_n(rst_n), .tck(tck), .tms_i(tms_i), .tms_drv(tms_drv), .tdi_i(tdi_i),
      .tdi_drv(tdi_drv), .tdo_o(tdo_o), .tdo_oe(tdo_oe), .ring_in(ring_in), .ring_out(ring_out),
      .ring_mode(ring_mode));
   sbst_tester sbst_tester_i (
      .tck(tck), .tms_i(tms_i), .tms_drv(tms_drv), .tdi_i(tdi_i), .tdi_drv(tdi_drv),
      .tdo_o(tdo_o), .tdo_oe(tdo_oe));
   always #2.5 mclk = ~mclk;
   task automatic check_data(input string what, input logic [31:0] exp, input logic [31:0] seen);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic check_mode(input string what, input sbst_mode_s exp, input sbst_mode_s seen);
      num_checks++;
      if (seen !== exp) begin
         mismatches++;
         $display("[FAIL] %s expected %b seen %b", what, exp, seen);
      end
   endtask
   task automatic complete_run;
      if (mismatches == 0 && num_checks > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // hang guard, far beyond the longest sequence
   initial begin
      #200000;
      mismatches++;
      complete_run;
   end
   // main sequence; mclk-side inputs move on the falling edge
   initial begin
      mclk = 1'b0;
      rst_n = 1'b0;
      ring_in = 16'hBEEF;
      mismatches = 0;
      num_checks = 0;
      repeat (3) @(negedge mclk);
      check_data("tdo enable at power-up", 32'h0, {31'h0, tdo_oe});
      rst_n = 1'b1;
      sbst_tester_i.reset_tap(1'b0);
      foreach (rows[k]) begin
         sbst_tester_i.scan(1'b1, 1'b0, 3, {29'h0, rows[k].ins}, got);
         check_data("ir capture", 32'h1, got & 32'h3);
         sbst_tester_i.scan(1'b0, rows[k].open, rows[k].len, rows[k].din, got);
         check_data("dr shift", rows[k].dout, got);
      end
      // the last update left the preload pattern; its hiz cell is low
      repeat (8) @(negedge mclk);
      check_data("preload ring", 32'h0000_3C96, {16'h0, ring_out});
      check_mode("sample mode", '{drive_ext: 1'b0, bus_hiz: 1'b0}, ring_mode);
      sbst_tester_i.scan(1'b1, 1'b0, 3, {29'h0, SBST_INS_EXTEST}, got);
      repeat (8) @(negedge mclk);
      check_mode("extest mode", '{drive_ext: 1'b1, bus_hiz: 1'b1}, ring_mode);
      // open mode pin resets the port; latch presets, id comes back
      sbst_tester_i.reset_tap(1'b1);
      repeat (8) @(negedge mclk);
      check_mode("mode after tap reset", SBST_MODE_RST, ring_mode);
      check_data("latch preset", 32'h0000_0200, {16'h0, ring_out});
      sbst_tester_i.scan(1'b0, 1'b0, 32, 32'h0, got);
      check_data("id after tap reset", SBST_IDCODE_VAL, got);
      // preset hiz cell lets extest drive the bus; sample z floats it
      sbst_tester_i.scan(1'b1, 1'b0, 3, {29'h0, SBST_INS_EXTEST}, got);
      repeat (8) @(negedge mclk);
      check_mode("extest preset mode", '{drive_ext: 1'b1, bus_hiz: 1'b0}, ring_mode);
      sbst_tester_i.scan(1'b1, 1'b0, 3, {29'h0, SBST_INS_SAMPZ}, got);
      repeat (8) @(negedge mclk);
      check_mode("sample z mode", '{drive_ext: 1'b0, bus_hiz: 1'b1}, ring_mode);
      // second reset in mid-run with tck parked
      rst_n = 1'b0;
      repeat (3) @(negedge mclk);
      check_data("ring in reset", 32'h0, {16'h0, ring_out});
      check_data("tdo enable in reset", 32'h0, {31'h0, tdo_oe});
      check_mode("mode in reset", SBST_MODE_RST, ring_mode);
      rst_n = 1'b1;
      sbst_tester_i.reset_tap(1'b0);
      sbst_tester_i.scan(1'b0, 1'b0, 32, 32'h0, got);
      check_data("id after reset", SBST_IDCODE_VAL, got);
      complete_run;
   end
endmodule
